// ==== hdl/sfp_params.svh ====
// constants of the serial flash front end: opcodes,
// array geometry, dummy counts and fifo size; included by the fifo interface, the front end, the properties and the bench
`ifndef SFP_PARAMS_SVH
`define SFP_PARAMS_SVH
`define SFP_OP_SETLATCH 8'h06
`define SFP_OP_CLRLATCH 8'h04
`define SFP_OP_STWR 8'h01
`define SFP_OP_STRD1 8'h05
`define SFP_OP_STRD2 8'h35
`define SFP_OP_PGWR 8'h02
`define SFP_OP_SECWIPE 8'h20
`define SFP_OP_BLK32WIPE 8'h52
`define SFP_OP_BLK64WIPE 8'hD8
`define SFP_OP_CHIPWIPE1 8'h60
`define SFP_OP_CHIPWIPE2 8'hC7
`define SFP_OP_RSTARM 8'h66
`define SFP_OP_RSTGO 8'h99
`define SFP_OP_SLEEP 8'hB9
`define SFP_OP_WAKE 8'hAB
`define SFP_OP_RD 8'h03
`define SFP_OP_FRD 8'h0B
`define SFP_OP_DOUT 8'h3B
`define SFP_OP_DIO 8'hBB
`define SFP_OP_QOUT 8'h6B
`define SFP_OP_QIO 8'hEB
`define SFP_DUMMY_FAST 4'h8
`define SFP_DUMMY_DIO 4'h4
`define SFP_DUMMY_QIO 4'h6
`define SFP_ADDR_W 20
`define SFP_ADDR_MAX 20'hFFFFF
`define SFP_LG_PAGE 5'h08
`define SFP_LG_SECTOR 5'h0C
`define SFP_LG_BLK32 5'h0F
`define SFP_LG_BLK64 5'h10
`define SFP_FIFO_W 8
`define SFP_FIFO_DEPTH 16
`define SFP_IDLE_BYTE 8'hFF
`endif

// ==== hdl/sfp_pkg.sv ====
// types of the serial flash front end
// assumes nothing of its surroundings
package sfp_pkg;
	typedef enum logic [4:0] {
		PH_CMD = 5'h01,
		PH_ADDR = 5'h02,
		PH_DUMMY = 5'h04,
		PH_DATA = 5'h08,
		PH_IGNORE = 5'h10
	} sfp_phase_t;
endpackage

// ==== hdl/sfp_fifo_if.sv ====
// carrier between the front end and its read-data fifo
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "sfp_params.svh"
interface sfp_fifo_if;
	logic [`SFP_FIFO_W-1:0] pushData;
	logic pushValid;
	logic pushReady;
	logic [`SFP_FIFO_W-1:0] popData;
	logic popValid;
	logic popReady;
	logic flush;
	modport store (input pushData, input pushValid, output pushReady,
		output popData, output popValid, input popReady, input flush);
	modport ctrl (output pushData, output pushValid, input pushReady,
		input popData, input popValid, output popReady, output flush);
endinterface
`default_nettype wire

// ==== hdl/sfp_stream_fifo.sv ====
// synchronous fifo with valid/ready on both sides and a flush
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module sfp_stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk, // clock
	input wire logic rst, // synchronous reset
	sfp_fifo_if.store bus // push and pop sides
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;
	logic notFull_q;
	logic doPush;
	logic doPop;

	assign doPush = bus.pushValid && notFull_q;
	assign doPop = bus.popReady && (count_q != '0);
	assign bus.pushReady = notFull_q;
	assign bus.popValid = (count_q != '0);
	assign bus.popData = mem[rdPtr_q];

	always_comb
	begin
		count_d = count_q;
		if (doPush && !doPop)
			count_d = count_q + 1'b1;
		else if (doPop && !doPush)
			count_d = count_q - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (doPush)
			mem[wrPtr_q] <= bus.pushData;
	end

	// full is registered so the ready seen upstream is a clean flop
	always_ff @(posedge clk)
	begin
		if (rst || bus.flush)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
			notFull_q <= 1'b1;
		end
		else
		begin
			if (doPush)
				wrPtr_q <= AW'(wrPtr_q + 1'b1);
			if (doPop)
				rdPtr_q <= AW'(rdPtr_q + 1'b1);
			count_q <= count_d;
			notFull_q <= (count_d != CW'(DEPTH));
		end
	end
endmodule
`default_nettype wire

// ==== hdl/sfp_flash_front.sv ====
// serial bus front end and write protection of a 1MB serial flash
// assumes pins arrive asynchronous to mclk; array engine sits outside
`timescale 1ns/100ps
`default_nettype none
`include "sfp_params.svh"
module sfp_flash_front (
	input wire logic mclk, // 125 MHz system clock
	input wire logic sys_rst, // synchronous reset, power-up
	input wire logic sclkPin, // serial clock from host
	input wire logic csPinN, // chip select, active low
	input wire logic [3:0] dataLineIn, // data_line_3..0 pin levels
	output logic [3:0] dataLineOut, // data_line_3..0 drive value
	output logic [3:0] dataLineOe, // high while driving the line
	input wire logic [7:0] rdByte, // array byte for the read stream
	input wire logic rdByteValid, // rdByte valid
	output logic rdByteReady, // fifo has room
	output logic [19:0] rdAddr, // start address of a read
	output logic rdStart, // pulse: read stream starts
	output logic [7:0] pgmByte, // byte received for page write
	output logic pgmStb, // pulse: pgmByte valid
	output logic [7:0] opCode, // accepted write or wipe opcode
	output logic [19:0] opAddr, // its aligned start address
	output logic opStart, // pulse: launch array operation
	output logic opRefused, // pulse: refused by protection
	input wire logic busyIn, // array engine busy
	output logic writeLatchFlag, // write enable latch
	output logic [4:0] protectRangeBits, // protected range code
	output logic rangeInvertBit, // protect the complement
	output logic quadLinesEnable, // quad lines, pause disabled
	output logic statusLockBitHi, // status lock, high bit
	output logic statusLockBitLo, // status lock, low bit
	output logic pausedOut, // bus paused
	output logic deepSleep // deep power-down
);
	sfp_pkg::sfp_phase_t phase_q;
	logic [2:0] sclkS;
	logic [2:0] csS;
	logic [3:0] dinS1;
	logic [3:0] dinS2;
	logic csLow;
	logic csRise;
	logic sclkRise;
	logic sclkFall;
	logic paused_q;
	logic [7:0] inShift_q;
	logic [3:0] bitCnt_q;
	logic [1:0] byteCnt_q;
	logic [3:0] dumCnt_q;
	logic [1:0] stBytes_q;
	logic [7:0] op_q;
	logic [23:0] addr_q;
	logic addrDone_q;
	logic [7:0] outShift_q;
	logic [3:0] outCnt_q;
	logic [3:0] lanes;
	logic [3:0] outLanes;
	logic [3:0] bitSum;
	logic byteDone;
	logic [7:0] shIn;
	logic [7:0] cur;
	logic popNow;
	logic frameEnd;
	logic endOk;
	logic locked;
	logic [7:0] sr1;
	logic [7:0] sr2;
	logic wel_q;
	logic sleep_q;
	logic arm_q;
	logic [4:0] bp_q;
	logic inv_q;
	logic quad_q;
	logic lockHi_q;
	logic lockLo_q;
	logic wipeOp;
	logic [4:0] span;
	logic [19:0] unitLo;
	logic [19:0] unitHi;
	sfp_fifo_if fifoBus();

	function automatic logic isArrayRead(input logic [7:0] op);
		return op == `SFP_OP_RD || op == `SFP_OP_FRD ||
			op == `SFP_OP_DOUT || op == `SFP_OP_DIO ||
			op == `SFP_OP_QOUT || op == `SFP_OP_QIO;
	endfunction

	function automatic logic isStatRead(input logic [7:0] op);
		return op == `SFP_OP_STRD1 || op == `SFP_OP_STRD2;
	endfunction

	function automatic logic [3:0] lanesOf(input sfp_pkg::sfp_phase_t ph,
		input logic [7:0] op);
		logic [3:0] n;
		n = 4'h1;
		if (ph != sfp_pkg::PH_CMD)
		begin
			if (op == `SFP_OP_DIO || (ph == sfp_pkg::PH_DATA &&
				op == `SFP_OP_DOUT))
				n = 4'h2;
			if (op == `SFP_OP_QIO || (ph == sfp_pkg::PH_DATA &&
				op == `SFP_OP_QOUT))
				n = 4'h4;
		end
		return n;
	endfunction

	function automatic logic [3:0] dummyOf(input logic [7:0] op);
		case (op)
			`SFP_OP_FRD, `SFP_OP_DOUT, `SFP_OP_QOUT: return `SFP_DUMMY_FAST;
			`SFP_OP_DIO: return `SFP_DUMMY_DIO;
			`SFP_OP_QIO: return `SFP_DUMMY_QIO;
			default: return 4'h0;
		endcase
	endfunction

	// everything but wake and the reset pair ends up ignored in sleep
	function automatic sfp_pkg::sfp_phase_t firstPhase(input logic [7:0] op,
		input logic sleep, input logic quad);
		if (sleep)
			return sfp_pkg::PH_IGNORE;
		case (op)
			`SFP_OP_RD, `SFP_OP_FRD, `SFP_OP_DOUT, `SFP_OP_DIO,
			`SFP_OP_PGWR, `SFP_OP_SECWIPE, `SFP_OP_BLK32WIPE,
			`SFP_OP_BLK64WIPE: return sfp_pkg::PH_ADDR;
			`SFP_OP_QOUT, `SFP_OP_QIO:
				return quad ? sfp_pkg::PH_ADDR : sfp_pkg::PH_IGNORE;
			`SFP_OP_STRD1, `SFP_OP_STRD2, `SFP_OP_STWR:
				return sfp_pkg::PH_DATA;
			default: return sfp_pkg::PH_IGNORE;
		endcase
	endfunction

	// protected ranges always touch an array end; the mask test is
	// exact because every range is a power of two in size
	function automatic logic isProt(input logic [4:0] bp, input logic inv,
		input logic [19:0] a);
		logic [4:0] lg;
		logic hit;
		lg = bp[4] ? (bp[2] ? 5'h0F : 5'h0B + {3'h0, bp[1:0]}) :
			5'h0F + {2'h0, bp[2:0]};
		if (bp[2:0] == 3'h0)
			hit = 1'b0;
		else if (bp[2:1] == 2'h3 || (!bp[4] && bp[2:0] == 3'h5))
			hit = 1'b1;
		else if (bp[3])
			hit = (a >> lg) == 20'h00000;
		else
			hit = (a >> lg) == (`SFP_ADDR_MAX >> lg);
		return hit ^ inv;
	endfunction

	// mode 0 and mode 3 look alike: only edges inside select count
	assign csLow = !csS[1];
	assign csRise = csS[1] && !csS[2];
	assign sclkRise = sclkS[1] && !sclkS[2] && csLow && !paused_q;
	assign sclkFall = !sclkS[1] && sclkS[2] && csLow && !paused_q;
	assign lanes = lanesOf(phase_q, op_q);
	assign outLanes = lanesOf(sfp_pkg::PH_DATA, op_q);
	assign bitSum = bitCnt_q + lanes;
	assign byteDone = (bitSum == 4'h8);
	assign shIn = (lanes == 4'h4) ? {inShift_q[3:0], dinS2} :
		(lanes == 4'h2) ? {inShift_q[5:0], dinS2[1:0]} :
		{inShift_q[6:0], dinS2[0]};
	assign sr1 = {lockLo_q, bp_q, wel_q, busyIn};
	assign sr2 = {1'b0, inv_q, 4'h0, quad_q, lockHi_q};
	// protect pin counts only while it is not a data line
	assign locked = lockHi_q || (lockLo_q && !quad_q && !dinS2[2]);
	assign popNow = sclkFall && phase_q == sfp_pkg::PH_DATA &&
		isArrayRead(op_q) && outCnt_q == 4'h0;
	assign cur = (outCnt_q != 4'h0) ? outShift_q :
		isStatRead(op_q) ? ((op_q == `SFP_OP_STRD1) ? sr1 : sr2) :
		fifoBus.popValid ? fifoBus.popData : `SFP_IDLE_BYTE;
	// a command counts only if its frame ended on a byte boundary
	// and no pause was active when select rose
	assign frameEnd = csRise && !paused_q && phase_q != sfp_pkg::PH_CMD &&
		bitCnt_q == 4'h0;
	assign endOk = frameEnd && (!sleep_q || op_q == `SFP_OP_WAKE ||
		op_q == `SFP_OP_RSTARM || op_q == `SFP_OP_RSTGO);
	assign wipeOp = ((op_q == `SFP_OP_PGWR || op_q == `SFP_OP_SECWIPE ||
		op_q == `SFP_OP_BLK32WIPE || op_q == `SFP_OP_BLK64WIPE) &&
		addrDone_q) || op_q == `SFP_OP_CHIPWIPE1 ||
		op_q == `SFP_OP_CHIPWIPE2;
	assign span = (op_q == `SFP_OP_PGWR) ? `SFP_LG_PAGE :
		(op_q == `SFP_OP_SECWIPE) ? `SFP_LG_SECTOR :
		(op_q == `SFP_OP_BLK32WIPE) ? `SFP_LG_BLK32 : `SFP_LG_BLK64;
	// a chip wipe spans the whole array; others their page, sector or block
	assign unitLo = wipeOp && (op_q == `SFP_OP_CHIPWIPE1 ||
		op_q == `SFP_OP_CHIPWIPE2) ? 20'h00000 :
		(addr_q[19:0] >> span) << span;
	assign unitHi = (op_q == `SFP_OP_CHIPWIPE1 ||
		op_q == `SFP_OP_CHIPWIPE2) ? `SFP_ADDR_MAX :
		unitLo | ~((`SFP_ADDR_MAX >> span) << span);

	assign fifoBus.pushData = rdByte;
	assign fifoBus.pushValid = rdByteValid;
	assign fifoBus.popReady = popNow;
	assign fifoBus.flush = !csLow;
	assign rdByteReady = fifoBus.pushReady;
	assign writeLatchFlag = wel_q;
	assign protectRangeBits = bp_q;
	assign rangeInvertBit = inv_q;
	assign quadLinesEnable = quad_q;
	assign statusLockBitHi = lockHi_q;
	assign statusLockBitLo = lockLo_q;
	assign pausedOut = paused_q;
	assign deepSleep = sleep_q;

	sfp_stream_fifo #(
		.WIDTH(`SFP_FIFO_W),
		.DEPTH(`SFP_FIFO_DEPTH)
	) u_fifo (
		.clk(mclk),
		.rst(sys_rst),
		.bus(fifoBus)
	);

	// first stage of each chain feeds only its second stage
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			sclkS <= 3'h0;
			csS <= 3'h7;
			dinS1 <= 4'hF;
			dinS2 <= 4'hF;
		end
		else
		begin
			sclkS <= {sclkS[1:0], sclkPin};
			csS <= {csS[1:0], csPinN};
			dinS1 <= dataLineIn;
			dinS2 <= dinS1;
		end
	end

	// level test on a clock-low moment stands in for the edge
	always_ff @(posedge mclk)
	begin
		if (sys_rst || !csLow || quad_q)
			paused_q <= 1'b0;
		else if (!sclkS[1] && !paused_q && !dinS2[3])
			paused_q <= 1'b1;
		else if (!sclkS[1] && paused_q && dinS2[3])
			paused_q <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst || !csLow)
		begin
			phase_q <= sfp_pkg::PH_CMD;
			inShift_q <= 8'h00;
			bitCnt_q <= 4'h0;
			byteCnt_q <= 2'h0;
			dumCnt_q <= 4'h0;
			stBytes_q <= 2'h0;
			op_q <= 8'h00;
			addr_q <= 24'h000000;
			addrDone_q <= 1'b0;
		end
		else if (sclkRise)
		begin
			inShift_q <= shIn;
			bitCnt_q <= byteDone ? 4'h0 : bitSum;
			case (phase_q)
				sfp_pkg::PH_CMD:
					if (byteDone)
					begin
						op_q <= shIn;
						phase_q <= firstPhase(shIn, sleep_q, quad_q);
					end
				sfp_pkg::PH_ADDR:
					if (byteDone)
					begin
						addr_q <= {addr_q[15:0], shIn};
						byteCnt_q <= byteCnt_q + 2'h1;
						if (byteCnt_q == 2'h2)
						begin
							addrDone_q <= 1'b1;
							phase_q <= (dummyOf(op_q) == 4'h0) ?
								sfp_pkg::PH_DATA : sfp_pkg::PH_DUMMY;
						end
					end
				sfp_pkg::PH_DUMMY:
				begin
					bitCnt_q <= 4'h0;
					dumCnt_q <= dumCnt_q + 4'h1;
					if (dumCnt_q == dummyOf(op_q) - 4'h1)
						phase_q <= sfp_pkg::PH_DATA;
				end
				sfp_pkg::PH_DATA:
					if (byteDone)
					begin
						stBytes_q <= stBytes_q + {1'b0, stBytes_q != 2'h3};
						if (op_q == `SFP_OP_STWR && !stBytes_q[1])
							addr_q <= {addr_q[15:0], shIn};
					end
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rdStart <= 1'b0;
			rdAddr <= 20'h00000;
			pgmStb <= 1'b0;
			pgmByte <= 8'h00;
		end
		else
		begin
			rdStart <= sclkRise && phase_q == sfp_pkg::PH_ADDR &&
				byteDone && byteCnt_q == 2'h2 && isArrayRead(op_q);
			if (sclkRise && phase_q == sfp_pkg::PH_ADDR && byteDone)
				rdAddr <= {addr_q[11:0], shIn};
			pgmStb <= sclkRise && phase_q == sfp_pkg::PH_DATA &&
				byteDone && op_q == `SFP_OP_PGWR;
			if (sclkRise && phase_q == sfp_pkg::PH_DATA && byteDone)
				pgmByte <= shIn;
		end
	end

	// output bits move only on falling edges; lines released on pause or deselect
	always_ff @(posedge mclk)
	begin
		if (sys_rst || !csLow)
		begin
			outShift_q <= 8'h00;
			outCnt_q <= 4'h0;
			dataLineOut <= 4'h0;
			dataLineOe <= 4'h0;
		end
		else if (paused_q)
			dataLineOe <= 4'h0;
		else if (sclkFall && phase_q == sfp_pkg::PH_DATA &&
			(isArrayRead(op_q) || isStatRead(op_q)))
		begin
			outShift_q <= cur << outLanes;
			outCnt_q <= ((outCnt_q == 4'h0) ? 4'h8 : outCnt_q) - outLanes;
			case (outLanes)
				4'h4:
				begin
					dataLineOut <= cur[7:4];
					dataLineOe <= 4'hF;
				end
				4'h2:
				begin
					dataLineOut <= {2'h0, cur[7:6]};
					dataLineOe <= 4'h3;
				end
				default:
				begin
					dataLineOut <= {2'h0, cur[7], 1'b0};
					dataLineOe <= 4'h2;
				end
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			wel_q <= 1'b0;
			sleep_q <= 1'b0;
			arm_q <= 1'b0;
		end
		else if (endOk)
		begin
			arm_q <= (op_q == `SFP_OP_RSTARM);
			case (op_q)
				`SFP_OP_SETLATCH: wel_q <= 1'b1;
				`SFP_OP_CLRLATCH, `SFP_OP_STWR, `SFP_OP_PGWR,
				`SFP_OP_SECWIPE, `SFP_OP_BLK32WIPE, `SFP_OP_BLK64WIPE,
				`SFP_OP_CHIPWIPE1, `SFP_OP_CHIPWIPE2:
					wel_q <= 1'b0;
				`SFP_OP_SLEEP: sleep_q <= 1'b1;
				`SFP_OP_WAKE: sleep_q <= 1'b0;
				`SFP_OP_RSTGO:
					if (arm_q)
					begin
						wel_q <= 1'b0;
						sleep_q <= 1'b0;
					end
				default: ;
			endcase
		end
	end

	// status fields are held across frames; only power-up clears them
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			bp_q <= 5'h00;
			inv_q <= 1'b0;
			quad_q <= 1'b0;
			lockHi_q <= 1'b0;
			lockLo_q <= 1'b0;
		end
		else if (endOk && op_q == `SFP_OP_STWR && wel_q && !locked &&
			stBytes_q != 2'h0)
		begin
			lockLo_q <= (stBytes_q == 2'h1) ? addr_q[7] : addr_q[15];
			bp_q <= (stBytes_q == 2'h1) ? addr_q[6:2] : addr_q[14:10];
			if (stBytes_q != 2'h1)
			begin
				lockHi_q <= addr_q[0];
				quad_q <= addr_q[1];
				inv_q <= addr_q[6];
			end
		end
	end

	// launch proceeds regardless of later pauses on the bus
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			opStart <= 1'b0;
			opRefused <= 1'b0;
			opCode <= 8'h00;
			opAddr <= 20'h00000;
		end
		else
		begin
			opStart <= 1'b0;
			opRefused <= 1'b0;
			if (endOk && wipeOp && wel_q)
			begin
				opCode <= op_q;
				opAddr <= unitLo;
				if (isProt(bp_q, inv_q, unitLo) ||
					isProt(bp_q, inv_q, unitHi))
					opRefused <= 1'b1;
				else
					opStart <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== dv/sfp_host_model.sv ====
// host controller model: mode 0 serial master for the front end
// assumes the bench resolves data_line_1, which the host never drives
`timescale 1ns/100ps
`default_nettype none
module sfp_host_model (
	input wire logic mclk, // bench clock, steps align to it
	input wire logic soLine, // resolved data_line_1 level
	output logic sclkPin, // serial clock, idles low
	output logic csPinN, // chip select, active low
	output logic [3:0] hostLine // drive on data lines 0, 2 and 3
);
	initial
	begin
		sclkPin = 1'b0;
		csPinN = 1'b1;
		hostLine = 4'hF;
	end
	task automatic pin(input int k, input logic v);
		@(posedge mclk);
		#1 hostLine[k] = v;
	endtask
	task automatic frameOpen();
		pin(3, 1'b1);
		#8 csPinN = 1'b0;
		#72;
	endtask
	task automatic frameClose();
		@(posedge mclk);
		#1 csPinN = 1'b1;
		repeat (12) @(posedge mclk);
	endtask
	// data moves while the clock is low, taken back on the rise
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			hostLine[0] = tx[i];
			#80 sclkPin = 1'b1;
			rx[i] = soLine;
			#80 sclkPin = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ==== dv/sfp_flash_front_properties.sv ====
// assertions on the front end ports
// assumes one clock domain, bound into sfp_flash_front
`timescale 1ns/100ps
`default_nettype none
`include "sfp_params.svh"
module sfp_flash_front_properties (
	input wire logic mclk, // clock
	input wire logic sys_rst, // sync reset
	input wire logic csPinN, // chip select
	input wire logic [3:0] dataLineOe, // line drive enables
	input wire logic [7:0] opCode, // array opcode
	input wire logic [19:0] opAddr, // array start address
	input wire logic opStart, // launch pulse
	input wire logic opRefused, // refusal pulse
	input wire logic writeLatchFlag, // write latch
	input wire logic [4:0] protectRangeBits, // range code
	input wire logic rangeInvertBit, // complement
	input wire logic quadLinesEnable, // quad mode
	input wire logic pausedOut, // paused
	input wire logic deepSleep, // power-down
	input wire logic rdStart // read start
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	sequence s_heldPaused;
		pausedOut [*4];
	endsequence
	sequence s_heldIdle;
		csPinN [*6];
	endsequence
	sequence s_chipWipe;
		opStart && opCode inside {`SFP_OP_CHIPWIPE1, `SFP_OP_CHIPWIPE2};
	endsequence
	chk_paused_lines: assert property (
		s_heldPaused |-> dataLineOe == 4'h0)
		else $error("lines driven while paused");
	chk_idle_lines: assert property (
		s_heldIdle |-> dataLineOe == 4'h0)
		else $error("lines driven while deselected");
	chk_pause_quad: assert property (
		pausedOut |-> !quadLinesEnable)
		else $error("pause with quad lines on");
	chk_quad_lines: assert property (
		dataLineOe[3:2] != 2'h0 |-> quadLinesEnable)
		else $error("upper lines driven with quad off");
	chk_latch_needed: assert property (
		opStart |-> $past(writeLatchFlag, 4))
		else $error("launch without write latch");
	chk_latch_drop: assert property (
		opStart |-> ##[0:2] !writeLatchFlag)
		else $error("latch kept after launch");
	chk_start_single: assert property (
		opStart |-> !opRefused ##1 !opStart)
		else $error("launch pulse malformed");
	chk_sector_align: assert property (
		opStart && opCode == `SFP_OP_SECWIPE |-> opAddr[11:0] == 12'h000)
		else $error("sector address not aligned");
	chk_chip_unprot: assert property (
		s_chipWipe |-> (!rangeInvertBit && protectRangeBits[2:0] == 3'h0) ||
		(rangeInvertBit && (protectRangeBits[2:1] == 2'h3 ||
		(!protectRangeBits[4] && protectRangeBits[2:0] == 3'h5))))
		else $error("chip wipe under protection");
	chk_sleep_quiet: assert property (
		deepSleep |-> !opStart && !rdStart)
		else $error("activity in power-down");
endmodule
bind sfp_flash_front sfp_flash_front_properties sfp_flash_front_properties_inst (
	.mclk, .sys_rst, .csPinN, .dataLineOe, .opCode, .opAddr, .opStart,
	.opRefused, .writeLatchFlag, .protectRangeBits, .rangeInvertBit,
	.quadLinesEnable, .pausedOut, .deepSleep, .rdStart);
`default_nettype wire

// ==== dv/sfp_flash_front_bench.sv ====
// self-checking bench of the serial flash front end
// assumes the host model drives the pins, the bench the array side
`timescale 1ns/100ps
`default_nettype none
`include "sfp_params.svh"
module sfp_flash_front_bench;
	logic mclk, sys_rst, sclkPin, csPinN, lastSo, busyIn;
	logic rdByteValid, rdByteReady, rdStart, opStart, opRefused;
	logic writeLatchFlag, statusLockBitLo, pausedOut, deepSleep;
	logic rangeInvertBit;
	logic [3:0] lineIn, dataLineOut, dataLineOe, hostLine;
	logic [7:0] rdByte, opCode, seenOp;
	logic [19:0] rdAddr, opAddr, seenAddr;
	logic [4:0] protectRangeBits;
	int nErrors = 0, totalChecks = 0, nStart = 0, nRef = 0;
	sfp_flash_front sfp_flash_front_inst (.mclk, .sys_rst, .sclkPin, .csPinN,
		.dataLineIn(lineIn), .dataLineOut, .dataLineOe, .rdByte, .rdByteValid,
		.rdByteReady, .rdAddr, .rdStart, .pgmByte(), .pgmStb(), .opCode,
		.opAddr, .opStart, .opRefused, .busyIn, .writeLatchFlag,
		.protectRangeBits, .rangeInvertBit, .quadLinesEnable(),
		.statusLockBitHi(), .statusLockBitLo, .pausedOut, .deepSleep);
	sfp_host_model sfp_host_model_inst (.mclk, .soLine(lineIn[1]), .sclkPin,
		.csPinN, .hostLine);
	// a released data_line_1 shows the inverse of its last driven bit, never a kind leftover
	always_comb
	begin
		lineIn = (dataLineOe & dataLineOut) | (~dataLineOe & hostLine);
		if (!dataLineOe[1])
			lineIn[1] = ~lastSo;
	end
	always @(posedge mclk)
	begin
		if (dataLineOe[1])
			lastSo <= dataLineOut[1];
		if (opStart)
			seenAddr <= opAddr;
		if (opStart)
			seenOp <= opCode;
		nStart <= nStart + int'(opStart);
		nRef <= nRef + int'(opRefused);
	end
	always #4 mclk = ~mclk;
	task automatic completeRun();
		if (nErrors == 0 && totalChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [19:0] exp,
		input logic [19:0] got);
		totalChecks++;
		if (got !== exp)
		begin
			nErrors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic frame(input logic [7:0] op, input logic [23:0] a,
		input int na);
		logic [7:0] rx;
		sfp_host_model_inst.frameOpen();
		sfp_host_model_inst.xfer(op, rx);
		for (int k = na - 1; k >= 0; k--)
			sfp_host_model_inst.xfer(a[8*k +: 8], rx);
		sfp_host_model_inst.frameClose();
	endtask
	task automatic testLatch();
		int s0;
		check("ready", 20'h1, 20'(rdByteReady));
		frame(`SFP_OP_SETLATCH, 24'h0, 0);
		check("latch set", 20'h1, 20'(writeLatchFlag));
		frame(`SFP_OP_CLRLATCH, 24'h0, 0);
		check("latch clear", 20'h0, 20'(writeLatchFlag));
		s0 = nStart + nRef;
		frame(`SFP_OP_SECWIPE, 24'h0, 3);
		check("unlatched wipe", 20'(s0), 20'(nStart + nRef));
	endtask
	task automatic testProtect();
		logic [4:0] bp [11] = '{5'h01, 5'h01, 5'h09, 5'h04, 5'h04, 5'h19,
			5'h19, 5'h15, 5'h00, 5'h06, 5'h00};
		logic [19:0] ad [11] = '{20'hFF123, 20'hEF000, 20'h0F000, 20'h80000,
			20'h7F000, 20'h00000, 20'h01000, 20'hF8000, 20'hFF000,
			20'h00000, 20'h00000};
		logic [10:0] refuse = 11'h2AD;
		int s0, r0;
		for (int i = 0; i < 11; i++)
		begin
			frame(`SFP_OP_SETLATCH, 24'h0, 0);
			frame(`SFP_OP_STWR, {16'h0, 1'b0, bp[i], 2'h0}, 1);
			check("range", 20'(bp[i]), 20'(protectRangeBits));
			check("latch", 20'h0, 20'(writeLatchFlag));
			s0 = nStart;
			r0 = nRef;
			frame(`SFP_OP_SETLATCH, 24'h0, 0);
			frame(i == 10 ? `SFP_OP_CHIPWIPE1 : `SFP_OP_SECWIPE,
				{4'h0, ad[i]}, i == 10 ? 0 : 3);
			check("refused", 20'(refuse[i]), 20'(nRef - r0));
			check("started", 20'(!refuse[i]), 20'(nStart - s0));
			if (!refuse[i] && i < 10)
				check("addr", ad[i] & 20'hFF000, seenAddr);
			if (!refuse[i] && i < 10)
				check("opcode", 20'(`SFP_OP_SECWIPE), 20'(seenOp));
		end
		frame(`SFP_OP_SETLATCH, 24'h0, 0);
		frame(`SFP_OP_STWR, 24'h1840, 2);
		check("invert", 20'h1, 20'(rangeInvertBit));
		s0 = nStart;
		frame(`SFP_OP_SETLATCH, 24'h0, 0);
		frame(`SFP_OP_CHIPWIPE2, 24'h0, 0);
		check("complement", 20'h1, 20'(nStart - s0));
	endtask
	task automatic testLock();
		logic [7:0] rx;
		frame(`SFP_OP_SETLATCH, 24'h0, 0);
		frame(`SFP_OP_STWR, 24'h80, 1);
		#1 busyIn = 1'b1;
		sfp_host_model_inst.frameOpen();
		sfp_host_model_inst.xfer(`SFP_OP_STRD1, rx);
		sfp_host_model_inst.xfer(8'hFF, rx);
		sfp_host_model_inst.frameClose();
		check("status", 20'h81, 20'(rx));
		sfp_host_model_inst.pin(2, 1'b0);
		frame(`SFP_OP_SETLATCH, 24'h0, 0);
		frame(`SFP_OP_STWR, 24'h04, 1);
		check("locked range", 20'h0, 20'(protectRangeBits));
		check("lock", 20'h1, 20'(statusLockBitLo));
		sfp_host_model_inst.pin(2, 1'b1);
		frame(`SFP_OP_SETLATCH, 24'h0, 0);
		frame(`SFP_OP_STWR, 24'h00, 1);
		check("unlock", 20'h0, 20'(statusLockBitLo));
	endtask
	task automatic testSleep();
		frame(`SFP_OP_SLEEP, 24'h0, 0);
		check("sleep", 20'h1, 20'(deepSleep));
		frame(`SFP_OP_SETLATCH, 24'h0, 0);
		check("sleep latch", 20'h0, 20'(writeLatchFlag));
		frame(`SFP_OP_WAKE, 24'h0, 0);
		check("wake", 20'h0, 20'(deepSleep));
		frame(`SFP_OP_SETLATCH, 24'h0, 0);
		frame(`SFP_OP_RSTARM, 24'h0, 0);
		frame(`SFP_OP_RSTGO, 24'h0, 0);
		check("reset latch", 20'h0, 20'(writeLatchFlag));
	endtask
	task automatic testRead();
		logic [7:0] rx;
		logic ok;
		int n = 0;
		int stalls = 0;
		sfp_host_model_inst.frameOpen();
		fork
			begin
				sfp_host_model_inst.xfer(`SFP_OP_RD, rx);
				for (int k = 2; k >= 0; k--)
					sfp_host_model_inst.xfer(8'(24'h012345 >> (8 * k)), rx);
				for (int k = 0; k < 19; k++)
				begin
					sfp_host_model_inst.xfer(8'hFF, rx);
					check("byte", k < 18 ? 20'(8'hA0 + k) : 20'hFF, 20'(rx));
				end
			end
			begin
				for (int w = 0; w < 900 && rdStart !== 1'b1; w++)
					@(posedge mclk) #1;
				if (rdStart !== 1'b1)
				begin
					nErrors++;
					completeRun();
				end
				check("read addr", 20'h12345, rdAddr);
				rdByte = 8'hA0;
				rdByteValid = 1'b1;
				for (int w = 0; w < 4000 && n < 18; w++)
				begin
					ok = rdByteReady;
					@(posedge mclk) #1;
					if (ok)
						n++;
					else
						stalls++;
					rdByte = 8'hA0 + 8'(n);
				end
				rdByteValid = 1'b0;
				check("pushed", 20'h12, 20'(n));
				check("fifo full", 20'h1, 20'(stalls > 0));
			end
		join
		sfp_host_model_inst.frameClose();
		check("drained", 20'h1, 20'(rdByteReady));
	endtask
	task automatic testPause();
		logic [7:0] rx;
		sfp_host_model_inst.frameOpen();
		sfp_host_model_inst.xfer(`SFP_OP_RD, rx);
		sfp_host_model_inst.pin(3, 1'b0);
		repeat (6) @(posedge mclk);
		check("paused", 20'h1, 20'(pausedOut));
		check("paused lines", 20'h0, 20'(dataLineOe));
		sfp_host_model_inst.pin(3, 1'b1);
		repeat (6) @(posedge mclk);
		check("resumed", 20'h0, 20'(pausedOut));
		sfp_host_model_inst.pin(3, 1'b0);
		repeat (6) @(posedge mclk);
		sfp_host_model_inst.frameClose();
		frame(`SFP_OP_SETLATCH, 24'h0, 0);
		check("after abort", 20'h1, 20'(writeLatchFlag));
	endtask
	initial
	begin
		mclk = 1'b0;
		sys_rst = 1'b1;
		busyIn = 1'b0;
		rdByte = 8'h00;
		rdByteValid = 1'b0;
		repeat (12) @(posedge mclk);
		#1 sys_rst = 1'b0;
		repeat (3) @(posedge mclk);
		testLatch();
		testProtect();
		testLock();
		testSleep();
		testRead();
		testPause();
		completeRun();
	end
endmodule
`default_nettype wire
